// file: rtl/capture_channel.sv
// one capture input: edge detect, count latch and its interrupt flag
`timescale 1ns/1ns
module capture_channel
   import tcc_pkg::*;
(
   input  wire logic               i_clk,
   input  wire logic               i_sys_rst,
   input  wire logic               i_sample,
   input  wire logic               i_rise_en,
   input  wire logic               i_fall_en,
   input  wire logic [COUNT_W-1:0] i_count,
   input  wire logic               i_flag_clr,
   output logic      [COUNT_W-1:0] o_capture,
   output logic                    o_flag
);

   logic               prev_ff;
   logic               primed_ff;
   logic [COUNT_W-1:0] capture_ff;
   logic               flag_ff;
   logic               hit;

   // selected edge between two successive samples
   always_comb begin
      hit = primed_ff & ((i_rise_en & ~prev_ff & i_sample) |
                         (i_fall_en & prev_ff & ~i_sample));
   end

   // sample history, once per cycle
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         prev_ff   <= 1'b0;
         primed_ff <= 1'b0;
      end else begin
         prev_ff   <= i_sample;
         primed_ff <= 1'b1;
      end
   end

   // latch the count at the end of the edge cycle
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         capture_ff <= COUNT_RST;
      end else if (hit) begin
         capture_ff <= i_count;
      end
   end

   // flag set wins over a clear in the same cycle
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         flag_ff <= 1'b0;
      end else begin
         flag_ff <= hit | (flag_ff & ~i_flag_clr);
      end
   end

   assign o_capture = capture_ff;
   assign o_flag    = flag_ff;

endmodule

// file: rtl/tcc_pkg.sv
// constants and carrier types for the timer capture/compare unit
package tcc_pkg;

   // counter and channel geometry
   localparam int COUNT_W      = 16;
   localparam int BYTE_W       = 8;
   localparam int NUM_CAPTURE  = 4;
   localparam int NUM_COMPARE  = 3;
   localparam int PORT_W       = 8;
   localparam int PORT_SR_BITS = 6;   // bits driven by set/reset compare
   localparam int PRE_W        = 3;   // prescaler counts up to divide by 8

   // compare register indices
   localparam int CMP_SET      = 0;
   localparam int CMP_RESET    = 1;
   localparam int CMP_TOGGLE   = 2;

   // capture edge control field layout, two bits per input
   localparam int EDGE_BITS_PER_CH = 2;
   localparam int EDGE_RISE_OFS    = 0;
   localparam int EDGE_FALL_OFS    = 1;

   // count source select codes
   localparam logic [1:0] SRC_OFF = 2'h0;
   localparam logic [1:0] SRC_OSC = 2'h1;   // oscillator / 6 = every cycle
   localparam logic [1:0] SRC_EXT = 2'h2;   // external count input

   // reset values, count steps and limits
   localparam logic [COUNT_W-1:0] COUNT_RST  = 16'h0000;
   localparam logic [COUNT_W-1:0] COUNT_ONE  = 16'h0001;
   localparam logic [COUNT_W-1:0] COUNT_MAX  = 16'hffff;
   localparam logic [BYTE_W-1:0]  BYTE_MAX   = 8'hff;
   localparam logic [PRE_W-1:0]   PRE_RST    = 3'h0;
   localparam logic [PRE_W-1:0]   PRE_ONE    = 3'h1;
   localparam logic [PORT_W-1:0]  PORT4_RST  = 8'h00;
   localparam logic [1:0]         TOGGLE_RST = 2'h3;  // first toggle sets

   // timer control field
   typedef struct packed {
      logic       wide_overflow_int_select;
      logic       byte_overflow_int_select;
      logic       ext_reset_enable;
      logic [1:0] source;
      logic [1:0] divide;       // 0:1, 1:2, 2:4, 3:8
   } timer_ctrl_t;

   // the nine interrupt flags of the unit
   typedef struct packed {
      logic                   wide_overflow_flag;
      logic                   byte_overflow_flag;
      logic [NUM_COMPARE-1:0] compare;
      logic [NUM_CAPTURE-1:0] capture;
   } flag_vec_t;

endpackage

// file: rtl/timer_capture_compare_unit.sv
// 16-bit timer with prescaler, four captures, three compares, port 4
// Function
// - 16-bit up-counter of two bytes, clocked by osc/6, external pin, or off.
// - external count pin sampled twice per cycle; low then high is an edge.
// - early edge increments next cycle; late edge increments one cycle later.
// - external counts accepted at most once per machine cycle.
// - prescaler divides by 1, 2, 4 or 8 under software control.
// - prescaler cleared on divide change, source change, or counter reset.
// - counter bytes readable live with no latch; counter not writable.
// - chip reset clears counter; enabled reset-pin rising edge clears both.
// - idle mode holds counter and prescaler in reset.
// - byte and wide overflow flags set one cycle after their overflow.
// - setting the wide overflow flag also sets the byte overflow flag.
// - overflow interrupt needs timer enable plus matching select bit.
// - both overflow requests share one interrupt output.
// - four capture registers load the count on edges and set flags.
// - each capture input enables rising, falling or both edges.
// - capture inputs sampled once per cycle; count latched at cycle end.
// - each increment compares the new count with three compare registers.
// - compare flag set at the end of the cycle after the match.
// - first compare match sets enabled port 4 bits 0 to 5.
// - second compare match clears enabled port 4 bits 0 to 5.
// - port bits 6 and 7 toggle via state flops; first toggle sets.
// - hardware port update beats a software write in the same cycle.
// - simultaneous set and reset of one port bit resets it.
`timescale 1ns/1ns
module timer_capture_compare_unit
   import tcc_pkg::*;
(
   input  wire logic                          i_clk,
   input  wire logic                          i_sys_rst,
   input  wire logic                          i_idle,
   input  wire logic                          i_count_sample_early,
   input  wire logic                          i_count_sample_late,
   input  wire logic                          i_ext_timer_reset_input,
   input  wire timer_ctrl_t                   i_timer_control_register,
   input  wire logic                          i_timer_interrupt_enable,
   input  wire logic [NUM_CAPTURE-1:0]        i_capture_inputs,
   input  wire logic [EDGE_BITS_PER_CH*NUM_CAPTURE-1:0]
                                              i_capture_edge_control,
   input  wire logic [COUNT_W-1:0]            i_compare_set_reg,
   input  wire logic [COUNT_W-1:0]            i_compare_reset_reg,
   input  wire logic [COUNT_W-1:0]            i_compare_toggle_reg,
   input  wire logic [PORT_SR_BITS-1:0]       i_set_enable_register,
   input  wire logic [PORT_W-1:0]             i_reset_toggle_enable_register,
   input  wire logic                          i_port_wr,
   input  wire logic [PORT_W-1:0]             i_port_wdata,
   input  wire flag_vec_t                     i_flag_clr,
   output logic      [BYTE_W-1:0]             o_count_high_byte,
   output logic      [BYTE_W-1:0]             o_count_low_byte,
   output logic      [NUM_CAPTURE-1:0][COUNT_W-1:0] o_capture_regs,
   output flag_vec_t                          o_timer_flag_register,
   output logic      [1:0]                    o_toggle_state,
   output logic      [PORT_W-1:0]             o_port4,
   output logic                               o_timer_irq
);

   // counter, prescaler and configuration history
   logic [COUNT_W-1:0]     count_ff;
   logic [COUNT_W-1:0]     nxt_count;
   logic [PRE_W-1:0]       pre_ff;
   logic [PRE_W-1:0]       pre_limit;
   logic [1:0]             src_prev_ff;
   logic [1:0]             div_prev_ff;
   logic                   cfg_changed;

   // external count pin edge pipeline
   logic                   late_prev_ff;
   logic                   early_edge_ff;
   logic                   late_edge_ff;
   logic                   late_edge_d2_ff;
   logic                   ext_tick;
   logic                   src_tick;
   logic                   inc;

   // external reset pin
   logic                   rst_pin_prev_ff;
   logic                   rst_pin_primed_ff;
   logic                   ext_rst_edge;
   logic                   timer_clr;

   // overflow and compare events
   logic                   byte_ovf_ev_ff;
   logic                   wide_ovf_ev_ff;
   logic                   byte_flag_ff;
   logic                   wide_flag_ff;
   logic [NUM_COMPARE-1:0] match_ff;
   logic [NUM_COMPARE-1:0] cmp_flag_ff;
   logic [NUM_COMPARE-1:0][COUNT_W-1:0] cmp_val;

   // port 4 and toggle state
   logic [PORT_W-1:0]      port_ff;
   logic [1:0]             toggle_ff;
   logic [PORT_W-1:0]      hw_set;
   logic [PORT_W-1:0]      hw_rst;
   logic [1:0]             hw_tog;

   // capture side
   logic [NUM_CAPTURE-1:0] cap_flag;

   assign cmp_val[CMP_SET]    = i_compare_set_reg;
   assign cmp_val[CMP_RESET]  = i_compare_reset_reg;
   assign cmp_val[CMP_TOGGLE] = i_compare_toggle_reg;

   // external count pin: early sample vs last late sample, late vs early
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         late_prev_ff    <= 1'b1;
         early_edge_ff   <= 1'b0;
         late_edge_ff    <= 1'b0;
         late_edge_d2_ff <= 1'b0;
      end else begin
         late_prev_ff    <= i_count_sample_late;
         early_edge_ff   <= ~late_prev_ff & i_count_sample_early;
         late_edge_ff    <= ~i_count_sample_early & i_count_sample_late;
         late_edge_d2_ff <= late_edge_ff;
      end
   end

   // at most one external count per cycle reaches the prescaler
   assign ext_tick = early_edge_ff | late_edge_d2_ff;

   // prescaler input from the selected source
   always_comb begin
      if (i_timer_control_register.source == SRC_OSC) begin
         src_tick = 1'b1;
      end else if (i_timer_control_register.source == SRC_EXT) begin
         src_tick = ext_tick;
      end else begin
         src_tick = 1'b0;                 // switched off
      end
   end

   // divide by 1, 2, 4 or 8
   always_comb begin
      pre_limit = PRE_W'((PRE_ONE << i_timer_control_register.divide)
                         - PRE_ONE);
      inc       = src_tick & (pre_ff == pre_limit);
      nxt_count = count_ff + COUNT_ONE;
   end

   // rising edge on the external reset pin when enabled
   assign ext_rst_edge = rst_pin_primed_ff & ~rst_pin_prev_ff &
                         i_ext_timer_reset_input &
                         i_timer_control_register.ext_reset_enable;
   assign timer_clr    = i_idle | ext_rst_edge;
   assign cfg_changed  =
      (i_timer_control_register.source != src_prev_ff) |
      (i_timer_control_register.divide != div_prev_ff);

   // reset pin and configuration history
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         rst_pin_prev_ff   <= 1'b0;
         rst_pin_primed_ff <= 1'b0;
         src_prev_ff       <= SRC_OFF;
         div_prev_ff       <= 2'h0;
      end else begin
         rst_pin_prev_ff   <= i_ext_timer_reset_input;
         rst_pin_primed_ff <= 1'b1;
         src_prev_ff       <= i_timer_control_register.source;
         div_prev_ff       <= i_timer_control_register.divide;
      end
   end

   // prescaler
   always_ff @(posedge i_clk) begin
      if (i_sys_rst || timer_clr || cfg_changed) begin
         pre_ff <= PRE_RST;
      end else if (src_tick) begin
         if (inc) begin
            pre_ff <= PRE_RST;
         end else begin
            pre_ff <= pre_ff + PRE_ONE;
         end
      end
   end

   // counter: no load path, only clear and increment
   always_ff @(posedge i_clk) begin
      if (i_sys_rst || timer_clr) begin
         count_ff <= COUNT_RST;
      end else if (inc) begin
         count_ff <= nxt_count;
      end
   end

   // overflow events held one cycle before the flags see them
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         byte_ovf_ev_ff <= 1'b0;
         wide_ovf_ev_ff <= 1'b0;
      end else begin
         byte_ovf_ev_ff <= inc & (count_ff[BYTE_W-1:0] == BYTE_MAX);
         wide_ovf_ev_ff <= inc & (count_ff == COUNT_MAX);
      end
   end

   // overflow flags; a set beats a software clear
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         byte_flag_ff <= 1'b0;
         wide_flag_ff <= 1'b0;
      end else begin
         byte_flag_ff <= byte_ovf_ev_ff | wide_ovf_ev_ff |
                         (byte_flag_ff &
                          ~i_flag_clr.byte_overflow_flag);
         wide_flag_ff <= wide_ovf_ev_ff |
                         (wide_flag_ff &
                          ~i_flag_clr.wide_overflow_flag);
      end
   end

   // compare the new count on every increment
   genvar c;
   generate
      for (c = 0; c < NUM_COMPARE; c = c + 1) begin : g_cmp
         always_ff @(posedge i_clk) begin
            if (i_sys_rst) begin
               match_ff[c]    <= 1'b0;
               cmp_flag_ff[c] <= 1'b0;
            end else begin
               match_ff[c]    <= inc & (nxt_count == cmp_val[c]);
               cmp_flag_ff[c] <= match_ff[c] |
                                 (cmp_flag_ff[c] &
                                  ~i_flag_clr.compare[c]);
            end
         end
      end
   endgenerate

   // per-bit hardware requests on port 4
   genvar b;
   generate
      for (b = 0; b < PORT_W; b = b + 1) begin : g_port
         if (b < PORT_SR_BITS) begin : g_sr
            assign hw_set[b] = match_ff[CMP_SET] &
                               i_set_enable_register[b];
            assign hw_rst[b] = match_ff[CMP_RESET] &
                               i_reset_toggle_enable_register[b];
         end else begin : g_tog
            assign hw_tog[b-PORT_SR_BITS] = match_ff[CMP_TOGGLE] &
                               i_reset_toggle_enable_register[b];
            assign hw_set[b] = hw_tog[b-PORT_SR_BITS] &
                               toggle_ff[b-PORT_SR_BITS];
            assign hw_rst[b] = hw_tog[b-PORT_SR_BITS] &
                               ~toggle_ff[b-PORT_SR_BITS];
         end

         // reset beats set, hardware beats software
         always_ff @(posedge i_clk) begin
            if (i_sys_rst) begin
               port_ff[b] <= PORT4_RST[b];
            end else if (hw_rst[b]) begin
               port_ff[b] <= 1'b0;
            end else if (hw_set[b]) begin
               port_ff[b] <= 1'b1;
            end else if (i_port_wr) begin
               port_ff[b] <= i_port_wdata[b];
            end
         end
      end
   endgenerate

   // last-operation flops; flip on each toggle, untouched by software
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         toggle_ff <= TOGGLE_RST;
      end else begin
         toggle_ff <= toggle_ff ^ hw_tog;
      end
   end

   // capture channels
   genvar k;
   generate
      for (k = 0; k < NUM_CAPTURE; k = k + 1) begin : g_cap
         capture_channel u_cap (
            .i_clk      (i_clk),
            .i_sys_rst  (i_sys_rst),
            .i_sample   (i_capture_inputs[k]),
            .i_rise_en  (i_capture_edge_control[EDGE_BITS_PER_CH*k +
                                                EDGE_RISE_OFS]),
            .i_fall_en  (i_capture_edge_control[EDGE_BITS_PER_CH*k +
                                                EDGE_FALL_OFS]),
            .i_count    (count_ff),
            .i_flag_clr (i_flag_clr.capture[k]),
            .o_capture  (o_capture_regs[k]),
            .o_flag     (cap_flag[k])
         );
      end
   endgenerate

   // live count bytes, no snapshot
   assign o_count_high_byte = count_ff[COUNT_W-1:BYTE_W];
   assign o_count_low_byte  = count_ff[BYTE_W-1:0];

   // flag register view
   assign o_timer_flag_register.wide_overflow_flag = wide_flag_ff;
   assign o_timer_flag_register.byte_overflow_flag = byte_flag_ff;
   assign o_timer_flag_register.compare            = cmp_flag_ff;
   assign o_timer_flag_register.capture            = cap_flag;

   assign o_toggle_state = toggle_ff;
   assign o_port4        = port_ff;

   // shared overflow interrupt request
   assign o_timer_irq = i_timer_interrupt_enable &
      ((i_timer_control_register.byte_overflow_int_select & byte_flag_ff) |
       (i_timer_control_register.wide_overflow_int_select &
        wide_flag_ff));

endmodule

// file: test/event_source.sv
// far-side model: count pin phases, reset pin and capture pins
`timescale 1ns/1ns
module event_source (
   input  wire logic       i_clk,
   output logic            o_early,
   output logic            o_late,
   output logic            o_rst_pin,
   output logic [3:0]      o_cap
);
   // pins rest low until a task moves them
   initial begin
      o_early = 1'b0;
      o_late = 1'b0;
      o_rst_pin = 1'b0;
      o_cap = 4'h0;
   end
   // count pin level at the two sample phases of the next cycle
   task automatic phase(input logic e, input logic l);
      @(negedge i_clk);
      o_early = e;
      o_late = l;
   endtask
   // full-rate edges: low first half, high second half
   task automatic burst(input int n);
      repeat (n) phase(1'b0, 1'b1);
      phase(1'b0, 1'b0);
   endtask
   // one-cycle high pulse on the reset pin
   task automatic rst_pulse;
      @(negedge i_clk);
      o_rst_pin = 1'b1;
      @(negedge i_clk);
      o_rst_pin = 1'b0;
   endtask
   task automatic cap(input logic [3:0] v);
      @(negedge i_clk);
      o_cap = v;
   endtask
endmodule

// file: test/tcc_properties.sv
// port checker for the timer capture/compare unit
`timescale 1ns/1ns
module tcc_properties
   import tcc_pkg::*;
(
   input wire logic                              i_clk,
   input wire logic                              i_sys_rst,
   input wire logic                              i_idle,
   input wire logic                              i_ext_timer_reset_input,
   input wire timer_ctrl_t                       i_timer_control_register,
   input wire logic                              i_timer_interrupt_enable,
   input wire logic [NUM_CAPTURE-1:0]            i_capture_inputs,
   input wire logic [EDGE_BITS_PER_CH*NUM_CAPTURE-1:0]
                                                 i_capture_edge_control,
   input wire logic [COUNT_W-1:0]                i_compare_set_reg,
   input wire logic [COUNT_W-1:0]                i_compare_reset_reg,
   input wire logic [PORT_SR_BITS-1:0]           i_set_enable_register,
   input wire logic [PORT_W-1:0]                 i_reset_toggle_enable_register,
   input wire flag_vec_t                         i_flag_clr,
   input wire logic [BYTE_W-1:0]                 o_count_high_byte,
   input wire logic [BYTE_W-1:0]                 o_count_low_byte,
   input wire logic [NUM_CAPTURE-1:0][COUNT_W-1:0] o_capture_regs,
   input wire flag_vec_t                         o_timer_flag_register,
   input wire logic [PORT_W-1:0]                 o_port4,
   input wire logic                              o_timer_irq
);
   timer_ctrl_t        c;
   flag_vec_t          f;
   logic [COUNT_W-1:0] cnt;
   // short aliases of the watched ports
   assign c = i_timer_control_register;
   assign f = o_timer_flag_register;
   assign cnt = {o_count_high_byte, o_count_low_byte};
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   property p_osc_step;
      (c.source == SRC_OSC && c.divide == 2'h0 && !c.ext_reset_enable
         && !i_idle) [*3] |-> cnt == $past(cnt) + COUNT_ONE;
   endproperty
   a_osc_step: assert property (p_osc_step)
      else $error("osc count did not step by one");
   property p_idle_clear;
      i_idle |=> cnt == COUNT_RST;
   endproperty
   a_idle_clear: assert property (p_idle_clear)
      else $error("idle did not clear count");
   property p_ext_reset;
      c.ext_reset_enable && $rose(i_ext_timer_reset_input)
         && !$past(i_sys_rst) |=> cnt == COUNT_RST;
   endproperty
   a_ext_reset: assert property (p_ext_reset)
      else $error("reset pin edge did not clear count");
   property p_wide_byte;
      $rose(f.wide_overflow_flag) |-> f.byte_overflow_flag;
   endproperty
   a_wide_byte: assert property (p_wide_byte)
      else $error("wide overflow without byte overflow");
   property p_irq;
      o_timer_irq == (i_timer_interrupt_enable
         && (f.byte_overflow_flag && c.byte_overflow_int_select
         || f.wide_overflow_flag && c.wide_overflow_int_select));
   endproperty
   a_irq: assert property (p_irq)
      else $error("overflow request wrong");
   property p_sticky;
      !$past(i_sys_rst) |-> (f & ($past(f) & ~$past(i_flag_clr)))
         == ($past(f) & ~$past(i_flag_clr));
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("flag dropped without clear");
   property p_capture0;
      i_capture_edge_control[EDGE_RISE_OFS] && $rose(i_capture_inputs[0])
         && !$past(i_sys_rst) && !$past(i_sys_rst, 2)
         |=> o_capture_regs[0] == $past(cnt) && f.capture[0];
   endproperty
   a_capture0: assert property (p_capture0)
      else $error("capture zero wrong");
   property p_cmp_set;
      cnt == $past(cnt) + COUNT_ONE && cnt == i_compare_set_reg
         && cnt != i_compare_reset_reg && $stable(i_compare_set_reg)
         |=> f.compare[CMP_SET] && (o_port4[5:0]
         & $past(i_set_enable_register)) == $past(i_set_enable_register);
   endproperty
   a_cmp_set: assert property (p_cmp_set)
      else $error("set compare effect wrong");
   property p_cmp_reset;
      cnt == $past(cnt) + COUNT_ONE && cnt == i_compare_reset_reg
         && $stable(i_compare_reset_reg) |=> f.compare[CMP_RESET]
         && (o_port4[5:0] & $past(i_reset_toggle_enable_register[5:0]))
         == 6'h00;
   endproperty
   a_cmp_reset: assert property (p_cmp_reset)
      else $error("reset compare effect wrong");
endmodule

bind timer_capture_compare_unit tcc_properties chk_u (
   .i_clk, .i_sys_rst, .i_idle, .i_ext_timer_reset_input,
   .i_timer_control_register, .i_timer_interrupt_enable,
   .i_capture_inputs, .i_capture_edge_control, .i_compare_set_reg,
   .i_compare_reset_reg, .i_set_enable_register,
   .i_reset_toggle_enable_register, .i_flag_clr, .o_count_high_byte,
   .o_count_low_byte, .o_capture_regs, .o_timer_flag_register,
   .o_port4, .o_timer_irq);

// file: test/timer_capture_compare_unit_tb_top.sv
// self-checking bench for the timer capture/compare unit
`timescale 1ns/1ns
module timer_capture_compare_unit_tb_top;
   import tcc_pkg::*;
   localparam int WD_CYC = 90000;  // tests take about 66k cycles
   logic             clk, rst, idle, irq_en, port_wr, irq;
   logic             early, late, rpin;
   timer_ctrl_t      ctl;
   flag_vec_t        clr, flags;
   logic [7:0]       edge_ctl, reset_toggle_enable_register, port_wd, hi, lo, port4;
   logic [5:0]       set_enable_register;
   logic [15:0]      cmp_s, cmp_r, cmp_t, cnt, c0, c1;
   logic [3:0][15:0] caps;
   logic [3:0]       cap_pins;
   logic [1:0]       tstate;
   int               bad_count = 0;
   int               n_compared = 0;
   assign cnt = {hi, lo};
   // 50 MHz machine-cycle clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   event_source src_u (.i_clk(clk), .o_early(early), .o_late(late),
                       .o_rst_pin(rpin), .o_cap(cap_pins));
   timer_capture_compare_unit dut_u (
      .i_clk(clk), .i_sys_rst(rst), .i_idle(idle),
      .i_count_sample_early(early), .i_count_sample_late(late),
      .i_ext_timer_reset_input(rpin), .i_timer_control_register(ctl),
      .i_timer_interrupt_enable(irq_en), .i_capture_inputs(cap_pins),
      .i_capture_edge_control(edge_ctl), .i_compare_set_reg(cmp_s),
      .i_compare_reset_reg(cmp_r), .i_compare_toggle_reg(cmp_t),
      .i_set_enable_register(set_enable_register), .i_reset_toggle_enable_register(reset_toggle_enable_register),
      .i_port_wr(port_wr), .i_port_wdata(port_wd), .i_flag_clr(clr),
      .o_count_high_byte(hi), .o_count_low_byte(lo), .o_capture_regs(caps),
      .o_timer_flag_register(flags), .o_toggle_state(tstate),
      .o_port4(port4), .o_timer_irq(irq));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude;
      $display("compared %0d, mismatched %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic wait_cnt(input logic [15:0] v);
      for (int i = 0; i < 70000 && cnt !== v; i++) cyc(1);
      check(cnt, v);
   endtask
   task automatic sw_write(input logic [7:0] v);
      port_wd = v;
      port_wr = 1'b1;
      cyc(1);
      port_wr = 1'b0;
      cyc(1);
   endtask
   // main sequence
   initial begin
      {rst, idle, irq_en, port_wr, ctl, clr} = '0;
      rst = 1'b1;
      {edge_ctl, reset_toggle_enable_register, port_wd, set_enable_register, cmp_s, cmp_r, cmp_t} = '0;
      cyc(20);
      rst = 1'b0;
      cyc(2);
      check(cnt, COUNT_RST);
      check(flags, 16'h0000);
      check(port4, PORT4_RST);
      check(tstate, TOGGLE_RST);
      $display("test reset done");
      ctl.source = SRC_OSC;
      for (int d = 0; d < 4; d++) begin
         ctl.divide = d[1:0];
         cyc(16);
         c0 = cnt;
         cyc(8 << d);
         check(cnt - c0, 16'h0008);
      end
      ctl.source = SRC_OFF;
      c0 = cnt;
      cyc(4);
      check(cnt, c0);
      idle = 1'b1;
      cyc(5);
      check(cnt, 16'h0000);
      $display("test prescale idle done");
      ctl = '0;
      ctl.source = SRC_EXT;
      cyc(1);
      idle = 1'b0;
      src_u.burst(8);
      cyc(3);
      check(cnt, 16'h0008);
      c0 = cnt;
      src_u.phase(1'b1, 1'b1);
      src_u.phase(1'b0, 1'b0);
      check(cnt, c0);
      cyc(1);
      check(cnt, c0 + 16'h0001);
      src_u.phase(1'b0, 1'b1);
      src_u.phase(1'b0, 1'b0);
      check(cnt, c0 + 16'h0001);
      cyc(1);
      check(cnt, c0 + 16'h0001);
      cyc(1);
      check(cnt, c0 + 16'h0002);
      src_u.rst_pulse;
      cyc(2);
      check(cnt, c0 + 16'h0002);
      ctl.ext_reset_enable = 1'b1;
      src_u.rst_pulse;
      cyc(1);
      check(cnt, 16'h0000);
      $display("test external done");
      ctl = '0;
      ctl.source = SRC_OSC;
      ctl.byte_overflow_int_select = 1'b1;
      irq_en = 1'b1;
      idle = 1'b1;
      clr = '1;
      cyc(1);
      {idle, clr} = '0;
      wait_cnt(16'h00ff);
      cyc(1);
      check(flags.byte_overflow_flag, 1'b0);
      cyc(1);
      check(flags.byte_overflow_flag, 1'b1);
      check(irq, 1'b1);
      clr.byte_overflow_flag = 1'b1;
      cyc(1);
      clr = '0;
      check(flags.byte_overflow_flag, 1'b0);
      check(irq, 1'b0);
      ctl.byte_overflow_int_select = 1'b0;
      cyc(300);
      check(flags.byte_overflow_flag, 1'b1);
      check(irq, 1'b0);
      ctl.wide_overflow_int_select = 1'b1;
      wait_cnt(16'hffff);
      cyc(2);
      check(flags.wide_overflow_flag, 1'b1);
      check(flags.byte_overflow_flag, 1'b1);
      check(irq, 1'b1);
      $display("test overflow done");
      edge_ctl = 8'h39;  // ch0 rise, ch1 fall, ch2 both, ch3 none
      src_u.cap(4'hf);
      c0 = cnt;
      cyc(1);
      check(caps[0], c0);
      check(caps[2], c0);
      check(caps[1], 16'h0000);
      check(flags.capture, 4'h5);
      clr.capture = 4'hf;
      cyc(1);
      clr = '0;
      src_u.cap(4'h0);
      c1 = cnt;
      cyc(1);
      check(caps[1], c1);
      check(caps[2], c1);
      check(caps[0], c0);
      check(caps[3], 16'h0000);
      check(flags.capture, 4'h6);
      $display("test capture done");
      {cmp_s, cmp_r, cmp_t} = {16'h0010, 16'h0020, 16'h0030};
      set_enable_register = 6'h3f;
      reset_toggle_enable_register = 8'hff;
      idle = 1'b1;
      clr = '1;
      cyc(1);
      {idle, clr} = '0;
      wait_cnt(16'h0010);
      check(flags.compare, 3'h0);
      cyc(1);
      check(port4, 8'h3f);
      check(flags.compare, 3'h1);
      wait_cnt(16'h0020);
      sw_write(8'hff);
      check(port4, 8'hc0);
      sw_write(8'h00);
      wait_cnt(16'h0030);
      cyc(1);
      check(port4, 8'hc0);
      check(tstate, 2'h0);
      sw_write(8'h00);
      cmp_t = 16'h0040;
      wait_cnt(16'h0040);
      cyc(1);
      check(port4, 8'h00);
      check(tstate, 2'h3);
      sw_write(8'h0f);
      {cmp_s, cmp_r} = {16'h0050, 16'h0050};
      wait_cnt(16'h0050);
      cyc(1);
      check(port4, 8'h00);
      check(flags.compare, 3'h7);
      $display("test compare done");
      conclude;
   end
   // cut a hang short
   initial begin
      #(WD_CYC * 20);
      bad_count++;
      $display("watchdog expired");
      conclude;
   end
endmodule
